/* File: hw/sebl_params.svh */
// constants for the serial eeprom boot loader
`ifndef SEBL_PARAMS_SVH
`define SEBL_PARAMS_SVH

`define SEBL_STREAM_KEY      16'h08aa
`define SEBL_FLASH_ENTRY     32'h003f7ff6
`define SEBL_RD_OPCODE       8'h03
`define SEBL_START_ADDR      16'h0000
`define SEBL_RSVD_WORDS      4'h7
`define SEBL_DIV_SLOWEST     7'h7f
`define SEBL_LSP_DEFAULT     7'h02
`define SEBL_HDR_BYTES       3'h3
// register offsets (byte addresses, 32-bit words)
`define SEBL_REG_CTRL        8'h00
`define SEBL_REG_STATUS      8'h04
`define SEBL_REG_ENTRY       8'h08
`define SEBL_REG_CLKCFG      8'h0c
`define SEBL_REG_IRQ_STAT    8'h10
`define SEBL_REG_IRQ_EN      8'h14
`define SEBL_REG_IRQ_CLR     8'h18
// interrupt bit positions and field width
`define SEBL_IRQ_DONE        0
`define SEBL_IRQ_KEYERR      1
`define SEBL_IRQ_BLOCK       2
`define SEBL_IRQ_W           3

`endif

/* File: hw/sebl_pkg.sv */
// types for the serial eeprom boot loader
package sebl_pkg;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000,
        ST_HDR   = 4'b0001,
        ST_KEY   = 4'b0010,
        ST_CLK   = 4'b0011,
        ST_RSVD  = 4'b0100,
        ST_ENTRY = 4'b0101,
        ST_SIZE  = 4'b0110,
        ST_DEST  = 4'b0111,
        ST_DATA  = 4'b1000,
        ST_DONE  = 4'b1001
    } sebl_state_t;

    // memory write port toward the loaded memory
    typedef struct packed {
        logic        we;
        logic [31:0] addr;
        logic [15:0] data;
    } sebl_mem_wr_t;

    // serial pins toward the eeprom
    typedef struct packed {
        logic sclk;
        logic mosi;
        logic cs_n;
    } sebl_spi_out_t;

endpackage : sebl_pkg

/* File: hw/sebl_loader.sv */
// serial eeprom boot loader: spi master, stream parser, memory copier
//
// The register addresses and strobed register access are this design's own decisions.
`include "sebl_params.svh"
`timescale 1ns/1ps
`default_nettype none

module sebl_loader (
    input  wire logic                 mclk_i,
    input  wire logic                 sys_rst_i,
    input  wire logic                 clk_en_i,
    input  wire logic                 boot_sel_eeprom_i,
    input  wire logic                 boot_start_i,
    input  wire logic                 spi_miso_i,
    output sebl_pkg::sebl_spi_out_t   spi_o,
    output logic                      eeprom_chip_select_o,
    output sebl_pkg::sebl_mem_wr_t    mem_wr_o,
    output logic                      done_o,
    output logic                      key_err_o,
    output logic [31:0]               entry_addr_o,
    output logic [6:0]                lsp_prescale_o,
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic [31:0]          reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output logic [31:0]               reg_rdata_o,
    output logic                      irq_o
);
    import sebl_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    sebl_state_t  state_r;
    logic [6:0]   div_r;         // bit-rate divider, half sclk period
    logic [6:0]   div_cnt_r;
    logic         sclk_r;
    logic [2:0]   bit_cnt_r;
    logic [7:0]   tx_sh_r;
    logic [7:0]   rx_sh_r;
    logic         byte_go_r;     // a byte transfer is in flight
    logic         byte_done_r;   // one-cycle pulse, rx_byte_r valid
    logic [7:0]   rx_byte_r;
    logic [2:0]   hdr_cnt_r;
    logic         half_r;        // 0: expecting low byte of a word
    logic [7:0]   lo_byte_r;
    logic [1:0]   word_cnt_r;
    logic [3:0]   rsvd_cnt_r;
    logic [15:0]  count_r;
    logic [31:0]  dest_r;
    logic [31:0]  entry_r;
    logic [15:0]  entry_hi_r;
    logic [15:0]  dest_hi_r;
    logic [`SEBL_IRQ_W-1:0] irq_stat_r;
    logic [`SEBL_IRQ_W-1:0] irq_en_r;
    logic         sw_start_r;

    logic         word_rdy;
    logic [15:0]  word;
    logic         busy;
    logic         start;
    logic [`SEBL_IRQ_W-1:0] irq_set;
    logic         sclk_tick;

    // ------------------------------------------------------------
    // word assembly
    // ------------------------------------------------------------
    // first byte received is low half, second high half
    assign word_rdy  = byte_done_r && half_r;
    assign word      = {rx_byte_r, lo_byte_r};
    assign busy      = (state_r != ST_IDLE) && (state_r != ST_DONE);
    assign start     = boot_sel_eeprom_i && (boot_start_i || sw_start_r);
    assign sclk_tick = byte_go_r && (div_cnt_r == 7'h00);

    // ------------------------------------------------------------
    // spi master: mode 0, msb first, 8-bit characters
    // ------------------------------------------------------------
    // the engine shifts bytes back to back so the burst never breaks
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_cnt_r   <= 7'h00;
            sclk_r      <= 1'b0;
            bit_cnt_r   <= 3'h0;
            tx_sh_r     <= 8'h00;
            rx_sh_r     <= 8'h00;
            byte_go_r   <= 1'b0;
            byte_done_r <= 1'b0;
            rx_byte_r   <= 8'h00;
        end else if (clk_en_i) begin
            byte_done_r <= 1'b0;
            if (!busy) begin
                byte_go_r <= 1'b0;
                sclk_r    <= 1'b0;
            end else if (!byte_go_r) begin
                byte_go_r <= 1'b1;
                div_cnt_r <= div_r;
                bit_cnt_r <= 3'h0;
                // header bytes carry opcode and zero address; hdr_cnt_r
                // lags the done pulse a cycle, so a fresh done means byte 2+
                if (state_r == ST_HDR && hdr_cnt_r == 3'h0 && !byte_done_r)
                    tx_sh_r <= `SEBL_RD_OPCODE;
                else
                    tx_sh_r <= 8'h00;
            end else if (sclk_tick) begin
                div_cnt_r <= div_r;
                sclk_r    <= ~sclk_r;
                if (sclk_r) begin
                    // the registered pin is high here unless div_r is 0, when it is still low: sample, phase 0
                    rx_sh_r   <= {rx_sh_r[6:0], spi_miso_i};
                    tx_sh_r   <= {tx_sh_r[6:0], 1'b0};
                    bit_cnt_r <= bit_cnt_r + 3'h1;
                    if (bit_cnt_r == 3'h7) begin
                        byte_go_r   <= 1'b0;
                        byte_done_r <= 1'b1;
                        rx_byte_r   <= {rx_sh_r[6:0], spi_miso_i};
                    end
                end
            end else begin
                div_cnt_r <= div_cnt_r - 7'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // stream parser and block copier
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r      <= ST_IDLE;
            hdr_cnt_r    <= 3'h0;
            half_r       <= 1'b0;
            lo_byte_r    <= 8'h00;
            word_cnt_r   <= 2'h0;
            rsvd_cnt_r   <= 4'h0;
            count_r      <= 16'h0000;
            dest_r       <= 32'h00000000;
            entry_r      <= 32'h00000000;
            entry_hi_r   <= 16'h0000;
            dest_hi_r    <= 16'h0000;
            div_r        <= `SEBL_DIV_SLOWEST;
            lsp_prescale_o <= `SEBL_LSP_DEFAULT;
            entry_addr_o <= 32'h00000000;
            done_o       <= 1'b0;
            key_err_o    <= 1'b0;
            mem_wr_o     <= '0;
            irq_set      <= '0;
        end else if (clk_en_i) begin
            mem_wr_o.we <= 1'b0;
            irq_set     <= '0;
            if (byte_done_r && state_r != ST_HDR) begin
                half_r <= ~half_r;
                if (!half_r)
                    lo_byte_r <= rx_byte_r;
            end
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        state_r   <= ST_HDR;
                        div_r     <= `SEBL_DIV_SLOWEST;
                        hdr_cnt_r <= 3'h0;
                        half_r    <= 1'b0;
                        done_o    <= 1'b0;
                        key_err_o <= 1'b0;
                    end
                end
                ST_HDR: begin
                    // opcode, address high, address low
                    if (byte_done_r) begin
                        hdr_cnt_r <= hdr_cnt_r + 3'h1;
                        if (hdr_cnt_r == `SEBL_HDR_BYTES - 3'h1)
                            state_r <= ST_KEY;
                    end
                end
                ST_KEY: begin
                    if (word_rdy) begin
                        if (word == `SEBL_STREAM_KEY) begin
                            state_r <= ST_CLK;
                        end else begin
                            entry_addr_o <= `SEBL_FLASH_ENTRY;
                            key_err_o    <= 1'b1;
                            done_o       <= 1'b1;
                            irq_set[`SEBL_IRQ_KEYERR] <= 1'b1;
                            irq_set[`SEBL_IRQ_DONE]   <= 1'b1;
                            state_r      <= ST_DONE;
                        end
                    end
                end
                ST_CLK: begin
                    // low byte prescaler, high byte divider
                    if (byte_done_r && !half_r)
                        lsp_prescale_o <= rx_byte_r[6:0];
                    if (word_rdy) begin
                        div_r      <= rx_byte_r[6:0];
                        rsvd_cnt_r <= 4'h0;
                        state_r    <= ST_RSVD;
                    end
                end
                ST_RSVD: begin
                    if (word_rdy) begin
                        rsvd_cnt_r <= rsvd_cnt_r + 4'h1;
                        if (rsvd_cnt_r == `SEBL_RSVD_WORDS - 4'h1) begin
                            word_cnt_r <= 2'h0;
                            state_r    <= ST_ENTRY;
                        end
                    end
                end
                ST_ENTRY: begin
                    if (word_rdy) begin
                        word_cnt_r <= word_cnt_r + 2'h1;
                        if (word_cnt_r == 2'h0) begin
                            entry_hi_r <= word;
                        end else begin
                            entry_r <= {entry_hi_r, word};
                            state_r <= ST_SIZE;
                        end
                    end
                end
                ST_SIZE: begin
                    if (word_rdy) begin
                        if (word == 16'h0000) begin
                            entry_addr_o <= entry_r;
                            done_o       <= 1'b1;
                            irq_set[`SEBL_IRQ_DONE] <= 1'b1;
                            state_r      <= ST_DONE;
                        end else begin
                            count_r    <= word;
                            word_cnt_r <= 2'h0;
                            state_r    <= ST_DEST;
                        end
                    end
                end
                ST_DEST: begin
                    if (word_rdy) begin
                        word_cnt_r <= word_cnt_r + 2'h1;
                        if (word_cnt_r == 2'h0) begin
                            dest_hi_r <= word;
                        end else begin
                            dest_r  <= {dest_hi_r, word};
                            state_r <= ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (word_rdy) begin
                        mem_wr_o.we   <= 1'b1;
                        mem_wr_o.addr <= dest_r;
                        mem_wr_o.data <= word;
                        dest_r        <= dest_r + 32'h1;
                        count_r       <= count_r - 16'h1;
                        if (count_r == 16'h0001) begin
                            irq_set[`SEBL_IRQ_BLOCK] <= 1'b1;
                            state_r <= ST_SIZE;
                        end
                    end
                end
                ST_DONE: begin
                    // new run needs start released first
                    if (!start)
                        state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pin outputs
    // ------------------------------------------------------------
    // select stays low for the whole burst so the eeprom keeps streaming
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            eeprom_chip_select_o <= 1'b1;
            spi_o <= '{sclk: 1'b0, mosi: 1'b0, cs_n: 1'b1};
        end else if (clk_en_i) begin
            eeprom_chip_select_o <= ~busy;
            spi_o.cs_n <= ~busy;
            spi_o.sclk <= sclk_r;
            spi_o.mosi <= tx_sh_r[7];
        end
    end

    // ------------------------------------------------------------
    // registers and interrupt
    // ------------------------------------------------------------
    // set wins over a clear in the same cycle
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_stat_r <= '0;
            irq_en_r   <= '0;
            sw_start_r <= 1'b0;
            irq_o      <= 1'b0;
        end else if (clk_en_i) begin
            if (reg_wr_i && reg_addr_i == `SEBL_REG_IRQ_CLR)
                irq_stat_r <= (irq_stat_r & ~reg_wdata_i[`SEBL_IRQ_W-1:0])
                              | irq_set;
            else
                irq_stat_r <= irq_stat_r | irq_set;
            if (reg_wr_i && reg_addr_i == `SEBL_REG_IRQ_EN)
                irq_en_r <= reg_wdata_i[`SEBL_IRQ_W-1:0];
            if (reg_wr_i && reg_addr_i == `SEBL_REG_CTRL)
                sw_start_r <= reg_wdata_i[0];
            irq_o <= |((irq_stat_r | irq_set) & irq_en_r);
        end
    end

    // read data appears the cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 32'h00000000;
        end else if (clk_en_i) begin
            reg_rdata_o <= 32'h00000000;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `SEBL_REG_CTRL:     reg_rdata_o <= {31'h0, sw_start_r};
                    `SEBL_REG_STATUS:   reg_rdata_o <= {25'h0, key_err_o,
                                           done_o, busy, state_r};
                    `SEBL_REG_ENTRY:    reg_rdata_o <= entry_addr_o;
                    `SEBL_REG_CLKCFG:   reg_rdata_o <= {17'h0, div_r,
                                           1'b0, lsp_prescale_o};
                    `SEBL_REG_IRQ_STAT: reg_rdata_o <= {29'h0, irq_stat_r};
                    `SEBL_REG_IRQ_EN:   reg_rdata_o <= {29'h0, irq_en_r};
                    default:            reg_rdata_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule : sebl_loader
`default_nettype wire

/* File: bench/sebl_eeprom_model.sv */
// behavioural byte-wide serial eeprom for the boot loader bench
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// eeprom model
// ------------------------------------------------------------
module sebl_eeprom_model (
    input  wire logic   cs_n_i,
    input  wire logic   sclk_i,
    input  wire logic   mosi_i,
    output logic        miso_o,
    output logic [23:0] cmd_o
);
    logic [7:0] mem [0:127];
    int         cnt;
    // quiet start values
    initial begin
        miso_o = 1'b0;
        cmd_o = 24'h0;
        cnt = 0;
    end
    // bit count restarts with every frame
    always @(negedge cs_n_i) cnt = 0;
    // command and address shift in on the rising clock, msb first
    always @(posedge sclk_i) begin
        if (!cs_n_i) begin
            if (cnt < 24) cmd_o = {cmd_o[22:0], mosi_i};
            cnt = cnt + 1;
        end
    end
    // image always served from location zero on; falling edge keeps mode 0
    always @(negedge sclk_i)
        if (!cs_n_i && cnt >= 24) miso_o = mem[(cnt-24)/8][7-(cnt-24)%8];
    // released line shows the inverse, so a late sample is caught
    always @(posedge cs_n_i) miso_o = ~miso_o;
endmodule : sebl_eeprom_model
`default_nettype wire

/* File: bench/sebl_loader_checker.sv */
// assertion checker for the serial eeprom boot loader
`include "sebl_params.svh"
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// checker module
// ------------------------------------------------------------
module sebl_loader_checker (
    input wire logic                    mclk_i,
    input wire logic                    sys_rst_i,
    input wire logic                    boot_sel_eeprom_i,
    input wire sebl_pkg::sebl_spi_out_t spi_o,
    input wire logic                    eeprom_chip_select_o,
    input wire sebl_pkg::sebl_mem_wr_t  mem_wr_o,
    input wire logic                    done_o,
    input wire logic                    key_err_o,
    input wire logic [31:0]             entry_addr_o,
    input wire logic [6:0]              lsp_prescale_o
);
    import sebl_pkg::*;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // serial clock parked low while a frame opens
    sequence s_sclk_quiet;
        !spi_o.sclk ##1 !spi_o.sclk;
    endsequence
    a_cs_pin_mirror: assert property (eeprom_chip_select_o == spi_o.cs_n)
        else $error("select pin differs from serial select");
    a_sclk_idle_low: assert property (spi_o.cs_n |-> !spi_o.sclk)
        else $error("serial clock not low while deselected");
    a_frame_opens_quiet: assert property ($fell(spi_o.cs_n) |-> s_sclk_quiet)
        else $error("serial clock moved as select fell");
    a_mosi_stable_rise: assert property ($rose(spi_o.sclk) |-> $stable(spi_o.mosi))
        else $error("mosi changed at the sampling edge");
    a_start_needs_sel: assert property ($fell(spi_o.cs_n) |-> $past(boot_sel_eeprom_i, 2))
        else $error("load started without eeprom boot mode");
    a_cs_held_burst: assert property ($rose(spi_o.cs_n) |-> ##[0:2] (done_o || key_err_o))
        else $error("select released before load ended");
    a_keyerr_entry: assert property ($rose(key_err_o) |-> ##[0:2] (entry_addr_o == `SEBL_FLASH_ENTRY))
        else $error("key error without flash entry");
    a_we_single: assert property (mem_wr_o.we |=> !mem_wr_o.we)
        else $error("memory write longer than one cycle");
    a_we_in_burst: assert property (mem_wr_o.we |-> !spi_o.cs_n && !done_o)
        else $error("memory write outside the burst");
    a_done_entry_hold: assert property (done_o && $past(done_o) |-> $stable(entry_addr_o))
        else $error("entry moved while done");
    a_lsp_in_load: assert property ($changed(lsp_prescale_o) |-> !spi_o.cs_n)
        else $error("prescaler changed outside a load");
endmodule : sebl_loader_checker
bind sebl_loader sebl_loader_checker u_chk (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .boot_sel_eeprom_i(boot_sel_eeprom_i),
    .spi_o(spi_o), .eeprom_chip_select_o(eeprom_chip_select_o),
    .mem_wr_o(mem_wr_o), .done_o(done_o), .key_err_o(key_err_o),
    .entry_addr_o(entry_addr_o), .lsp_prescale_o(lsp_prescale_o)
);
`default_nettype wire

/* File: bench/sebl_loader_tb.sv */
// self-checking testbench for the serial eeprom boot loader
`include "sebl_params.svh"
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// testbench top
// ------------------------------------------------------------
module sebl_loader_tb;
    import sebl_pkg::*;
    logic          mclk_i, sys_rst_i, boot_sel, boot_start, miso, irq;
    logic          done_o, key_err_o, cs_pin, reg_wr, reg_rd;
    logic [7:0]    reg_addr;
    logic [31:0]   reg_wdata, reg_rdata, entry;
    logic [6:0]    lsp;
    logic [23:0]   cmd;
    sebl_spi_out_t spi;
    sebl_mem_wr_t  mem_wr;
    logic [47:0]   wr_q [$];
    int            errors, n_tests, wp;

    sebl_loader dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
        .boot_sel_eeprom_i(boot_sel), .boot_start_i(boot_start),
        .spi_miso_i(miso), .spi_o(spi), .eeprom_chip_select_o(cs_pin),
        .mem_wr_o(mem_wr), .done_o(done_o), .key_err_o(key_err_o),
        .entry_addr_o(entry), .lsp_prescale_o(lsp), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .irq_o(irq));
    sebl_eeprom_model u_eep (.cs_n_i(spi.cs_n), .sclk_i(spi.sclk),
        .mosi_i(spi.mosi), .miso_o(miso), .cmd_o(cmd));

    // clock, 10 ns period
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    // collect every word written to memory
    always @(posedge mclk_i)
        if (mem_wr.we === 1'b1) wr_q.push_back({mem_wr.addr, mem_wr.data});

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge mclk_i);
        reg_wr <= 1'b0;
    endtask : reg_write
    // read data stand only in the cycle after the strobe
    task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk_i);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge mclk_i);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : reg_check
    // image words go out low byte first
    task automatic put_w(input logic [15:0] w);
        u_eep.mem[wp] = w[7:0];
        u_eep.mem[wp+1] = w[15:8];
        wp = wp + 2;
    endtask : put_w
    task automatic wait_end();
        int n;
        n = 0;
        while (done_o !== 1'b1 && key_err_o !== 1'b1 && n < 40000) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 40000) chk(0, 1);
        #1;
    endtask : wait_end

    task automatic t_no_sel();
        boot_start <= 1'b1;
        repeat (300) @(posedge mclk_i);
        #1 chk(spi.cs_n, 1'b1);
        $display("test no_sel done");
    endtask : t_no_sel
    task automatic t_good_load();
        logic [47:0] exp_w [4] = '{48'h0000_8000_2211, 48'h0000_8001_4433,
                                   48'h0000_8002_6655, 48'h0001_0020_beef};
        wp = 0;
        put_w(`SEBL_STREAM_KEY);
        put_w(16'h0005); // prescaler 5, then divider 0 for a fast copy
        for (int i = 0; i < 7; i++) put_w(16'hffff);
        put_w(16'h0012);
        put_w(16'h3456);
        put_w(16'h0003);
        put_w(16'h0000);
        put_w(16'h8000);
        put_w(16'h2211);
        put_w(16'h4433);
        put_w(16'h6655);
        put_w(16'h0001);
        put_w(16'h0001);
        put_w(16'h0020);
        put_w(16'hbeef);
        put_w(16'h0000);
        wr_q.delete();
        @(posedge mclk_i);
        boot_sel <= 1'b1;
        wait_end();
        chk(done_o, 1'b1);
        chk(key_err_o, 1'b0);
        chk(entry, 32'h0012_3456);
        chk(lsp, 7'h05);
        chk(cmd, {`SEBL_RD_OPCODE, `SEBL_START_ADDR});
        chk(wr_q.size(), 4);
        foreach (exp_w[i]) chk(wr_q[i], exp_w[i]);
        reg_check(`SEBL_REG_ENTRY, 32'h0012_3456);
        reg_check(`SEBL_REG_STATUS, 32'h0000_0029);
        reg_check(`SEBL_REG_CLKCFG, 32'h0000_0005);
        reg_check(8'h40, 32'h0);
        reg_write(`SEBL_REG_IRQ_EN, 32'h0);
        repeat (2) @(posedge mclk_i);
        #1 chk(irq, 1'b0);
        reg_check(`SEBL_REG_IRQ_STAT, 32'h5);
        reg_write(`SEBL_REG_IRQ_EN, 32'h1);
        repeat (2) @(posedge mclk_i);
        #1 chk(irq, 1'b1);
        reg_write(`SEBL_REG_IRQ_CLR, 32'h1);
        repeat (2) @(posedge mclk_i);
        #1 chk(irq, 1'b0);
        reg_check(`SEBL_REG_IRQ_STAT, 32'h4);
        $display("test good_load done");
    endtask : t_good_load
    task automatic t_key_err();
        @(posedge mclk_i);
        boot_start <= 1'b0;
        repeat (4) @(posedge mclk_i);
        wp = 0;
        put_w(16'h08ab);
        wr_q.delete();
        reg_write(`SEBL_REG_IRQ_EN, 32'h2);
        reg_write(`SEBL_REG_CTRL, 32'h1);
        repeat (5) @(posedge mclk_i);
        wait_end();
        chk(key_err_o, 1'b1);
        chk(entry, `SEBL_FLASH_ENTRY);
        chk(wr_q.size(), 0);
        repeat (2) @(posedge mclk_i);
        #1 chk(irq, 1'b1);
        $display("test key_err done");
    endtask : t_key_err

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    // watchdog: the loads need about 26k cycles, so allow more than twice that
    initial begin
        repeat (60000) @(posedge mclk_i);
        errors++;
        report_and_stop();
    end
    // main sequence
    initial begin
        errors = 0;
        n_tests = 0;
        wp = 0;
        sys_rst_i = 1'b1;
        boot_sel = 1'b0;
        boot_start = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        repeat (20) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        t_no_sel();
        t_good_load();
        t_key_err();
        report_and_stop();
    end
endmodule : sebl_loader_tb
`default_nettype wire
